// ===== sim/kpd_host_model.sv
// Two-wire bus host driving the keypad block's serial pins.
// Assumes a wired-and data line with a pull-up.
`timescale 1ns/1ns
module kpd_host_model (
  input wire logic clk_i,
  input wire logic dev_oe_n_i,
  output logic scl_o,
  output logic sda_o
);
  logic rel;
  // Pull-up wins unless either side pulls low
  assign sda_o = rel & dev_oe_n_i;
  initial begin
    scl_o = 1'b1;
    rel = 1'b1;
  end
  task automatic q();
    repeat (8) @(posedge clk_i);
  endtask
  task automatic start();
    rel <= 1'b1;
    q();
    scl_o <= 1'b1;
    q();
    rel <= 1'b0;
    q();
    scl_o <= 1'b0;
    q();
  endtask
  task automatic stop();
    rel <= 1'b0;
    q();
    scl_o <= 1'b1;
    q();
    rel <= 1'b1;
    q();
  endtask
  task automatic bit_x(input logic b, output logic s);
    rel <= b;
    q();
    scl_o <= 1'b1;
    q();
    s = sda_o;
    q();
    scl_o <= 1'b0;
    q();
  endtask
  task automatic xfer(input logic [7:0] d, input logic ak,
                      output logic [7:0] r, output logic k);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], b);
      r[i] = b;
    end
    bit_x(ak, k);
  endtask
endmodule

// ===== sim/kpd_top_monitor.sv
// Pin-level checker for the keypad block top.
// Assumes it is bound into kpd_top with a short scan period.
`timescale 1ns/1ns
module kpd_top_monitor #(
  parameter int SCAN_PERIOD_CYC = 200
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic scl_i,
  input wire logic [7:0] row_i,
  input wire logic row_pu_en_o,
  input wire logic [9:0] col_o,
  input wire logic [9:0] col_oe_n_o,
  input wire logic sda_o,
  input wire logic sda_oe_n_o,
  input wire logic int_o
);
  localparam int MAXW = SCAN_PERIOD_CYC + 100;
  logic [6:0] run_ff;
  logic [6:0] nxt_run;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  always_comb begin
    nxt_run = (col_o != 10'h000) ? run_ff + 7'h01 : 7'h00;
  end
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i)
      run_ff <= 7'h00;
    else
      run_ff <= nxt_run;
  end
  property p_col_drv;
    col_oe_n_o == 10'h000;
  endproperty
  a_col_drv: assert property (p_col_drv)
    else $error("column enable released");
  property p_pull_up;
    $past(resetn_i, 4) |-> row_pu_en_o;
  endproperty
  a_pull_up: assert property (p_pull_up)
    else $error("row pull-ups off");
  property p_one_low;
    col_o == 10'h000 || $onehot(~col_o);
  endproperty
  a_one_low: assert property (p_one_low)
    else $error("more than one column low");
  property p_dwell;
    $changed(col_o) && col_o != 10'h000 |=> $stable(col_o)[*5];
  endproperty
  a_dwell: assert property (p_dwell)
    else $error("column dwell short");
  property p_scan_len;
    run_ff <= 7'h3c;
  endproperty
  a_scan_len: assert property (p_scan_len)
    else $error("scan too long");
  property p_scan_start;
    $fell(&row_i) && col_o == 10'h000 |-> ##[1:MAXW] col_o != 10'h000;
  endproperty
  a_scan_start: assert property (p_scan_start)
    else $error("no scan after row low");
  property p_od_low;
    int_o == 1'b0 && sda_o == 1'b0;
  endproperty
  a_od_low: assert property (p_od_low)
    else $error("open-drain level not low");
  property p_sda_hold;
    $changed(sda_oe_n_o) |-> !scl_i && !$past(scl_i);
  endproperty
  a_sda_hold: assert property (p_sda_hold)
    else $error("data changed with clock high");
endmodule

// ===== sim/kpd_top_tb_top.sv
// Self-checking bench for the keypad block: host bus, keys, inputs.
// Assumes the host model and checker are compiled before this file.
`timescale 1ns/1ns
module kpd_top_tb_top;
  logic clk, resetn, scl, sda, sda_d, sda_oe_n, pu_en, int_d, int_oe_n;
  logic lock_state, lock_start, gpi_ev;
  logic [7:0] row, gpi_data, d0, d1;
  logic [9:0] col, col_oe_n;
  logic [79:0] keys;
  int fails, checked;
  kpd_top #(.SCAN_PERIOD_CYC(200)) u_kpd_top (
    .ref_clk_i(clk), .resetn_i(resetn), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_d), .sda_oe_n_o(sda_oe_n), .row_i(row),
    .row_pu_en_o(pu_en), .col_o(col), .col_oe_n_o(col_oe_n),
    .lock_state_i(lock_state), .lock_start_i(lock_start),
    .gpi_event_i(gpi_ev), .gpi_data_i(gpi_data), .int_o(int_d),
    .int_oe_n_o(int_oe_n)
  );
  kpd_host_model u_kpd_host_model (
    .clk_i(clk), .dev_oe_n_i(sda_oe_n), .scl_o(scl), .sda_o(sda)
  );
  // Rows follow the driven columns one cycle late, like real pins
  function automatic logic [7:0] rows_of(logic [79:0] k, logic [9:0] c);
    logic [7:0] r;
    r = 8'hff;
    for (int i = 0; i < 80; i++)
      if (k[i] && !c[i % 10])
        r[i / 10] = 1'b0;
    return r;
  endfunction
  always @(posedge clk)
    row <= rows_of(keys, col | col_oe_n);
  function automatic logic [7:0] b8(logic b);
    return {7'h00, b};
  endfunction
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic stop_test();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    logic [7:0] r;
    logic k;
    u_kpd_host_model.start();
    u_kpd_host_model.xfer(8'h54, 1'b1, r, k);
    u_kpd_host_model.xfer(a, 1'b1, r, k);
    u_kpd_host_model.xfer(d, 1'b1, r, k);
    chk("write ack", 8'h00, b8(k));
    u_kpd_host_model.stop();
  endtask
  task automatic rd(logic [7:0] a, int n, output logic [7:0] f,
                    output logic [7:0] l);
    logic [7:0] r;
    logic k;
    u_kpd_host_model.start();
    u_kpd_host_model.xfer(8'h54, 1'b1, r, k);
    u_kpd_host_model.xfer(a, 1'b1, r, k);
    u_kpd_host_model.start();
    u_kpd_host_model.xfer(8'h55, 1'b1, r, k);
    chk("read ack", 8'h00, b8(k));
    for (int i = 0; i < n; i++) begin
      u_kpd_host_model.xfer(8'hff, i == n - 1, r, k);
      if (i == 0)
        f = r;
      l = r;
    end
    u_kpd_host_model.stop();
  endtask
  task automatic wait_cnt(logic [7:0] e);
    logic [7:0] c, x;
    for (int i = 0; i < 12; i++) begin
      rd(kpd_pkg::REG_EVT_CNT, 1, c, x);
      if (c === e)
        break;
    end
    chk("event count", e, c);
  endtask
  task automatic gpi(logic [7:0] v);
    @(posedge clk);
    gpi_ev <= 1'b1;
    gpi_data <= v;
    @(posedge clk);
    gpi_ev <= 1'b0;
  endtask
  task automatic lock_go();
    @(posedge clk);
    lock_start <= 1'b1;
    @(posedge clk);
    lock_start <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic t_reset();
    rd(kpd_pkg::REG_CFG, 1, d0, d1);
    chk("cfg reset", kpd_pkg::CFG_RST, d0);
    rd(8'h7f, 1, d0, d1);
    chk("unmapped read", 8'h00, d0);
    chk("row pull-ups", 8'h01, b8(pu_en));
    chk("idle columns", 8'h01, b8(col === 10'h000));
    chk("int idle", 8'h01, b8(int_oe_n));
  endtask
  task automatic t_step();
    wr(kpd_pkg::REG_CFG, 8'h40);
    rd(kpd_pkg::REG_CFG, 2, d0, d1);
    chk("no step", 8'h40, d1);
    wr(kpd_pkg::REG_CFG, 8'hc0);
    rd(kpd_pkg::REG_CFG, 2, d0, d1);
    chk("step", 8'h00, d1);
    wr(kpd_pkg::REG_CFG, 8'h01);
  endtask
  task automatic t_key();
    @(posedge clk);
    keys[22] <= 1'b1;
    repeat (150) @(posedge clk);
    chk("one scan only", 8'h01, b8(int_oe_n));
    wait_cnt(8'h01);
    chk("key int", 8'h00, b8(int_oe_n));
    rd(kpd_pkg::REG_EVT, 1, d0, d1);
    chk("press byte", 8'h97, d0);
    keys[22] <= 1'b0;
    wait_cnt(8'h01);
    rd(kpd_pkg::REG_EVT, 1, d0, d1);
    chk("release byte", 8'h17, d0);
    wr(kpd_pkg::REG_INT_STAT, 8'h1f);
  endtask
  task automatic t_salute();
    keys <= 80'h100401;
    wait_cnt(8'h03);
    rd(kpd_pkg::REG_INT_STAT, 1, d0, d1);
    chk("salute flag", 8'h10, d0 & 8'h10);
    keys <= 80'h0;
    wait_cnt(8'h06);
    rd(kpd_pkg::REG_EVT, 6, d0, d1);
    chk("first is press", 8'h80, d0 & 8'h80);
    wr(kpd_pkg::REG_INT_STAT, 8'h1f);
    rd(kpd_pkg::REG_INT_STAT, 1, d0, d1);
    chk("flags cleared", 8'h00, d0);
  endtask
  task automatic t_lock();
    lock_state <= 1'b1;
    wr(kpd_pkg::REG_CFG, 8'h40);
    gpi(8'h5a);
    wr(kpd_pkg::REG_CFG, 8'h00);
    gpi(8'h5b);
    rd(kpd_pkg::REG_EVT, 2, d0, d1);
    chk("locked input", 8'h5b, d0);
    chk("one kept", 8'h00, d1);
    lock_state <= 1'b0;
    lock_go();
    rd(kpd_pkg::REG_INT_STAT, 1, d0, d1);
    chk("lock masked", 8'h00, d0 & 8'h04);
    wr(kpd_pkg::REG_CFG, 8'h04);
    lock_go();
    chk("lock int", 8'h00, b8(int_oe_n));
    wr(kpd_pkg::REG_INT_STAT, 8'h1f);
    chk("int cleared", 8'h01, b8(int_oe_n));
  endtask
  task automatic t_ovf(logic [7:0] cf, logic [7:0] first, logic [7:0] st);
    wr(kpd_pkg::REG_CFG, cf);
    for (int i = 0; i < 11; i++)
      gpi(8'h10 + 8'(i));
    rd(kpd_pkg::REG_EVT_CNT, 1, d0, d1);
    chk("full count", 8'h0a, d0);
    rd(kpd_pkg::REG_INT_STAT, 1, d0, d1);
    chk("overflow flag", st, d0 & 8'h08);
    if (st != 8'h00)
      chk("overflow int", 8'h00, b8(int_oe_n));
    else
      chk("no overflow int", 8'h01, b8(int_oe_n));
    rd(kpd_pkg::REG_EVT, 10, d0, d1);
    chk("oldest kept", first, d0);
    chk("newest kept", first + 8'h09, d1);
    wr(kpd_pkg::REG_INT_STAT, 8'h08);
    rd(kpd_pkg::REG_INT_STAT, 1, d0, d1);
    chk("overflow clear", 8'h00, d0 & 8'h08);
  endtask
  task automatic t_int(logic [7:0] cf);
    int n;
    wr(kpd_pkg::REG_CFG, cf);
    gpi(8'h33);
    repeat (4) @(posedge clk);
    chk("int on input", 8'h00, b8(int_oe_n));
    wr(kpd_pkg::REG_INT_STAT, 8'h02);
    chk("int after clear", b8(cf[4]), b8(int_oe_n));
    n = 0;
    while (int_oe_n !== 1'b0 && n < 1100) begin
      @(posedge clk);
      n++;
    end
    chk("gap length", b8(cf[4]), b8(n > 850));
    chk("int back", 8'h00, b8(int_oe_n));
    rd(kpd_pkg::REG_EVT, 1, d0, d1);
    wr(kpd_pkg::REG_INT_STAT, 8'h1f);
    chk("int released", 8'h01, b8(int_oe_n));
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    resetn = 1'b0;
    keys = 80'h0;
    lock_state = 1'b0;
    lock_start = 1'b0;
    gpi_ev = 1'b0;
    gpi_data = 8'h00;
    fails = 0;
    checked = 0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    repeat (10) @(posedge clk);
    t_reset();
    t_step();
    t_key();
    t_salute();
    t_lock();
    t_ovf(8'h08, 8'h10, 8'h00);
    t_ovf(8'h28, 8'h11, 8'h08);
    t_int(8'h02);
    t_int(8'h12);
    stop_test();
  end
endmodule
bind kpd_top kpd_top_monitor #(.SCAN_PERIOD_CYC(SCAN_PERIOD_CYC))
  u_kpd_top_monitor (
  .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .scl_i(scl_i),
  .row_i(row_i), .row_pu_en_o(row_pu_en_o), .col_o(col_o),
  .col_oe_n_o(col_oe_n_o), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
  .int_o(int_o)
);

// ===== src/kpd_evt_if.sv
// Key event stream from the scanner to the top.
// Assumes both ends share one clock.
`timescale 1ns/1ns
interface kpd_evt_if;
  logic valid;
  logic ready;
  logic [7:0] data;
  logic salute;
  modport src(output valid, output data, output salute, input ready);
  modport dst(input valid, input data, input salute, output ready);
endinterface

// ===== src/kpd_fifo.sv
// Ten-entry event queue with drop or wrap on overflow.
// Assumes one push and one pop request per cycle at most.
`timescale 1ns/1ns
module kpd_fifo (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic push_i,
  input wire logic [7:0] data_i,
  input wire logic wrap_i,
  input wire logic pop_i,
  output logic [7:0] data_o,
  output logic [3:0] count_o,
  output logic lost_o
);
  logic [7:0] mem_ff [kpd_pkg::FIFO_DEPTH];
  logic [3:0] head_ff, nxt_head, tail_ff, nxt_tail, cnt_ff, nxt_cnt;
  logic lost_ff, nxt_lost, wr_en, do_pop, full;

  function automatic logic [3:0] inc(input logic [3:0] p);
    inc = (p == 4'(kpd_pkg::FIFO_DEPTH - 1)) ? 4'h0 : p + 4'h1;
  endfunction

  always_comb begin
    full = (cnt_ff == 4'(kpd_pkg::FIFO_DEPTH));
    do_pop = pop_i && (cnt_ff != 4'h0);
    nxt_head = do_pop ? inc(head_ff) : head_ff;
    nxt_tail = tail_ff;
    nxt_cnt = cnt_ff;
    nxt_lost = 1'b0;
    wr_en = 1'b0;
    if (push_i) begin
      if (!full || do_pop) begin
        wr_en = 1'b1;
        nxt_tail = inc(tail_ff);
        nxt_cnt = do_pop ? cnt_ff : cnt_ff + 4'h1;
      end else if (wrap_i) begin
        // Oldest entry sits at tail when full
        wr_en = 1'b1;
        nxt_tail = inc(tail_ff);
        nxt_head = inc(head_ff);
        nxt_lost = 1'b1;
      end else begin
        nxt_lost = 1'b1;
      end
    end else if (do_pop) begin
      nxt_cnt = cnt_ff - 4'h1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      head_ff <= 4'h0;
      tail_ff <= 4'h0;
      cnt_ff <= 4'h0;
      lost_ff <= 1'b0;
    end else begin
      head_ff <= nxt_head;
      tail_ff <= nxt_tail;
      cnt_ff <= nxt_cnt;
      lost_ff <= nxt_lost;
    end
  end

  always_ff @(posedge clk_i) begin
    if (wr_en) begin
      mem_ff[tail_ff] <= data_i;
    end
  end

  assign data_o = mem_ff[head_ff];
  assign count_o = cnt_ff;
  assign lost_o = lost_ff;
endmodule

// ===== src/kpd_pkg.sv
// Constants shared by the keypad event, config and scan block.
// Assumes a 20 MHz core clock and a host on a two-wire serial bus.
package kpd_pkg;
  localparam int CLK_MHZ = 20;
  localparam int SCAN_PERIOD_US = 25000;
  localparam int SCAN_PERIOD_CYC = SCAN_PERIOD_US * CLK_MHZ;
  localparam int INT_GAP_US = 50;
  localparam int INT_GAP_CYC = INT_GAP_US * CLK_MHZ;
  localparam logic [10:0] INT_GAP_LOAD = 11'(INT_GAP_CYC);
  localparam logic [2:0] SETTLE_LAST = 3'h5;
  localparam int ROWS = 8;
  localparam int COLS = 10;
  localparam int KEYS = 80;
  localparam int FIFO_DEPTH = 10;
  localparam logic [7:0] REG_CFG = 8'h01;
  localparam logic [7:0] REG_INT_STAT = 8'h02;
  localparam logic [7:0] REG_EVT_CNT = 8'h03;
  localparam logic [7:0] REG_EVT = 8'h04;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] STAT_MASK = 8'h1f;
  localparam int CFG_KE_IEN = 0;
  localparam int CFG_GPI_IEN = 1;
  localparam int CFG_LOCK_IRQ_EN = 2;
  localparam int CFG_WRAP_IRQ_EN = 3;
  localparam int CFG_INT_CFG = 4;
  localparam int CFG_WRAP_MODE = 5;
  localparam int CFG_LOCK_TRACK = 6;
  localparam int CFG_ADDR_STEP = 7;
  localparam int ST_KEY = 0;
  localparam int ST_GPI = 1;
  localparam int ST_LOCK = 2;
  localparam int ST_WRAP = 3;
  localparam int ST_SALUTE = 4;
  localparam int SALUTE_K0 = 0;
  localparam int SALUTE_K1 = 10;
  localparam int SALUTE_K2 = 20;
  localparam int EVT_PRESS_BIT = 7;
  // Bus address is arbitrary
  localparam logic [6:0] DEV_ADDR = 7'h2a;
endpackage

// ===== src/kpd_scan.sv
// Column sweep scanner with two-scan confirmation.
// Assumes row inputs are already synchronised to clk_i.
`timescale 1ns/1ns
module kpd_scan #(
  parameter int SCAN_PERIOD_CYC = kpd_pkg::SCAN_PERIOD_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] row_i,
  output logic [9:0] col_o,
  output logic [9:0] col_oe_n_o,
  kpd_evt_if.src ev
);
  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_SCAN = 3'h1,
    S_CMP = 3'h2,
    S_RPT = 3'h3,
    S_WAIT = 3'h4
  } kpd_scan_st_t;
  kpd_scan_st_t st_ff, nxt_st;
  logic [79:0] cur_ff, nxt_cur, prev_ff, nxt_prev;
  logic [79:0] rep_ff, nxt_rep, chg_ff, nxt_chg;
  logic [3:0] col_ff, nxt_col;
  logic [2:0] set_ff, nxt_set;
  logic [6:0] idx_ff, nxt_idx;
  logic [31:0] tmr_ff, nxt_tmr;
  logic [9:0] colv_ff, nxt_colv;
  logic sal_ff, nxt_sal, begin_scan;
  localparam logic [2:0] SETTLE_LAST_L = kpd_pkg::SETTLE_LAST;

  always_comb begin
    nxt_st = st_ff;
    nxt_cur = cur_ff;
    nxt_prev = prev_ff;
    nxt_rep = rep_ff;
    nxt_chg = chg_ff;
    nxt_col = col_ff;
    nxt_set = set_ff;
    nxt_idx = idx_ff;
    nxt_tmr = (tmr_ff != 32'h0) ? tmr_ff - 32'h1 : tmr_ff;
    nxt_colv = 10'h000;
    begin_scan = 1'b0;
    case (st_ff)
      S_IDLE: begin
        begin_scan = !(&row_i);
      end
      S_SCAN: begin
        nxt_colv = ~(10'h001 << col_ff);
        nxt_set = set_ff + 3'h1;
        if (set_ff == SETTLE_LAST_L) begin
          nxt_set = 3'h0;
          for (int r = 0; r < kpd_pkg::ROWS; r++) begin
            nxt_cur[r * kpd_pkg::COLS + int'(col_ff)] = ~row_i[r];
          end
          if (col_ff == 4'(kpd_pkg::COLS - 1)) begin
            // Last column keeps its full dwell; compare state idles it
            nxt_st = S_CMP;
          end else begin
            nxt_col = col_ff + 4'h1;
          end
        end
      end
      S_CMP: begin
        // A key changes only when this scan agrees with the last
        nxt_chg = ~(cur_ff ^ prev_ff) & (cur_ff ^ rep_ff);
        nxt_prev = cur_ff;
        nxt_idx = 7'h00;
        nxt_st = S_RPT;
      end
      S_RPT: begin
        if (!chg_ff[idx_ff] || ev.ready) begin
          if (chg_ff[idx_ff]) begin
            nxt_rep[idx_ff] = ~rep_ff[idx_ff];
          end
          if (idx_ff == 7'(kpd_pkg::KEYS - 1)) begin
            nxt_st = S_WAIT;
          end else begin
            nxt_idx = idx_ff + 7'h01;
          end
        end
      end
      S_WAIT: begin
        if (tmr_ff == 32'h0) begin
          begin_scan = (|rep_ff) || (|prev_ff) || !(&row_i);
          nxt_st = S_IDLE;
        end
      end
      default: nxt_st = S_IDLE;
    endcase
    if (begin_scan) begin
      nxt_st = S_SCAN;
      nxt_col = 4'h0;
      nxt_set = 3'h0;
      nxt_tmr = 32'(SCAN_PERIOD_CYC - 1);
    end
    nxt_sal = nxt_rep[kpd_pkg::SALUTE_K0] & nxt_rep[kpd_pkg::SALUTE_K1]
      & nxt_rep[kpd_pkg::SALUTE_K2]
      & ~(rep_ff[kpd_pkg::SALUTE_K0] & rep_ff[kpd_pkg::SALUTE_K1]
      & rep_ff[kpd_pkg::SALUTE_K2]);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff <= S_IDLE;
      cur_ff <= '0;
      prev_ff <= '0;
      rep_ff <= '0;
      chg_ff <= '0;
      col_ff <= 4'h0;
      set_ff <= 3'h0;
      idx_ff <= 7'h00;
      tmr_ff <= 32'h0;
      colv_ff <= 10'h000;
      sal_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      cur_ff <= nxt_cur;
      prev_ff <= nxt_prev;
      rep_ff <= nxt_rep;
      chg_ff <= nxt_chg;
      col_ff <= nxt_col;
      set_ff <= nxt_set;
      idx_ff <= nxt_idx;
      tmr_ff <= nxt_tmr;
      colv_ff <= nxt_colv;
      sal_ff <= nxt_sal;
    end
  end

  assign ev.valid = (st_ff == S_RPT) && chg_ff[idx_ff];
  assign ev.data = {~rep_ff[idx_ff], idx_ff + 7'h01};
  assign ev.salute = sal_ff;
  assign col_o = colv_ff;
  assign col_oe_n_o = 10'h000;
endmodule

// ===== src/kpd_top.sv
// Keypad block top: serial register slave, config, status, interrupt.
// Assumes gpi and lock inputs come from logic on ref_clk_i; the
// serial bus and rows are pins and are synchronised here.
`timescale 1ns/1ns
module kpd_top #(
  parameter int SCAN_PERIOD_CYC = kpd_pkg::SCAN_PERIOD_CYC
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  input wire logic [7:0] row_i,
  output logic row_pu_en_o,
  output logic [9:0] col_o,
  output logic [9:0] col_oe_n_o,
  input wire logic lock_state_i,
  input wire logic lock_start_i,
  input wire logic gpi_event_i,
  input wire logic [7:0] gpi_data_i,
  output logic int_o,
  output logic int_oe_n_o
);
  typedef enum logic [2:0] {
    I_IDLE = 3'h0,
    I_ADDR = 3'h1,
    I_ACKA = 3'h2,
    I_WR = 3'h3,
    I_ACKW = 3'h4,
    I_RD = 3'h5,
    I_ACKR = 3'h6
  } kpd_bus_st_t;

  logic [1:0] rst_sync_ff;
  logic rst_n;
  logic [7:0] row_s1_ff;
  logic [7:0] row_s2_ff;
  logic [2:0] scl_sync_ff;
  logic [2:0] sda_sync_ff;
  logic scl_s, scl_d, sda_s, sda_d;
  logic bus_start, bus_stop, scl_rise, scl_fall;

  kpd_bus_st_t ist_ff, nxt_ist;
  logic [7:0] sr_ff, nxt_sr;
  logic [7:0] tx_ff, nxt_tx;
  logic [7:0] ptr_ff, nxt_ptr;
  logic [3:0] cnt_ff, nxt_cnt;
  logic drv_ff, nxt_drv;
  logic first_ff, nxt_first;
  logic rw_ff, nxt_rw;
  logic reg_wr, reg_rd;
  logic [7:0] step;
  logic [7:0] rd_data;

  logic [7:0] cfg_ff, nxt_cfg;
  logic [7:0] stat_ff, nxt_stat;
  logic [10:0] gap_ff, nxt_gap;
  logic int_oe_n_ff, nxt_int_oe_n;
  logic [7:0] clr, set, keep;
  logic pend;

  logic gpi_rec, push, pop, fifo_lost;
  logic [7:0] push_data, fifo_data;
  logic [3:0] fifo_cnt;
  logic pu_ff;

  kpd_evt_if ev ();

  // Reset: asserts at once, releases after two edges
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // Pin synchronisers; stage 0 is read only by stage 1
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      row_s1_ff <= 8'hff;
      row_s2_ff <= 8'hff;
      scl_sync_ff <= 3'h7;
      sda_sync_ff <= 3'h7;
      pu_ff <= 1'b0;
    end else begin
      row_s1_ff <= row_i;
      row_s2_ff <= row_s1_ff;
      scl_sync_ff <= {scl_sync_ff[1:0], scl_i};
      sda_sync_ff <= {sda_sync_ff[1:0], sda_i};
      pu_ff <= 1'b1;
    end
  end

  assign scl_s = scl_sync_ff[1];
  assign scl_d = scl_sync_ff[2];
  assign sda_s = sda_sync_ff[1];
  assign sda_d = sda_sync_ff[2];
  assign bus_start = scl_s && scl_d && sda_d && !sda_s;
  assign bus_stop = scl_s && scl_d && !sda_d && sda_s;
  assign scl_rise = scl_s && !scl_d;
  assign scl_fall = !scl_s && scl_d;
  assign step = cfg_ff[kpd_pkg::CFG_ADDR_STEP] ? 8'h01 : 8'h00;

  // Read data follows the pointer; reserved status bits read zero
  always_comb begin
    case (ptr_ff)
      kpd_pkg::REG_CFG: rd_data = cfg_ff;
      kpd_pkg::REG_INT_STAT: rd_data = stat_ff & kpd_pkg::STAT_MASK;
      kpd_pkg::REG_EVT_CNT: rd_data = {4'h0, fifo_cnt};
      kpd_pkg::REG_EVT: rd_data = (fifo_cnt != 4'h0) ? fifo_data : 8'h00;
      default: rd_data = 8'h00;
    endcase
  end

  // Serial slave: sample on scl rise, change sda on scl fall
  always_comb begin
    nxt_ist = ist_ff;
    nxt_sr = sr_ff;
    nxt_tx = tx_ff;
    nxt_ptr = ptr_ff;
    nxt_cnt = cnt_ff;
    nxt_drv = drv_ff;
    nxt_first = first_ff;
    nxt_rw = rw_ff;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    if (bus_stop) begin
      nxt_ist = I_IDLE;
      nxt_drv = 1'b0;
    end else if (bus_start) begin
      nxt_ist = I_ADDR;
      nxt_cnt = 4'h0;
      nxt_drv = 1'b0;
    end else begin
      case (ist_ff)
        I_ADDR, I_WR: begin
          if (scl_rise) begin
            nxt_sr = {sr_ff[6:0], sda_s};
            nxt_cnt = cnt_ff + 4'h1;
          end else if (scl_fall && cnt_ff == 4'h8) begin
            nxt_cnt = 4'h0;
            if (ist_ff == I_ADDR) begin
              if (sr_ff[7:1] == kpd_pkg::DEV_ADDR) begin
                nxt_drv = 1'b1;
                nxt_rw = sr_ff[0];
                nxt_first = 1'b1;
                nxt_ist = I_ACKA;
              end else begin
                nxt_ist = I_IDLE;
              end
            end else begin
              nxt_drv = 1'b1;
              nxt_first = 1'b0;
              nxt_ist = I_ACKW;
              if (first_ff) begin
                nxt_ptr = sr_ff;
              end else begin
                reg_wr = 1'b1;
                nxt_ptr = ptr_ff + step;
              end
            end
          end
        end
        I_ACKA, I_ACKW: begin
          if (scl_fall) begin
            if (ist_ff == I_ACKA && rw_ff) begin
              reg_rd = 1'b1;
              nxt_tx = rd_data;
              nxt_drv = ~rd_data[7];
              nxt_ptr = ptr_ff + step;
              nxt_ist = I_RD;
            end else begin
              nxt_drv = 1'b0;
              nxt_ist = I_WR;
            end
          end
        end
        I_RD: begin
          if (scl_fall) begin
            nxt_cnt = cnt_ff + 4'h1;
            if (cnt_ff == 4'h7) begin
              nxt_drv = 1'b0;
              nxt_ist = I_ACKR;
            end else begin
              nxt_tx = {tx_ff[6:0], 1'b0};
              nxt_drv = ~tx_ff[6];
            end
          end
        end
        I_ACKR: begin
          // A nack ends the read; the pop already happened
          if (scl_rise && sda_s) begin
            nxt_ist = I_IDLE;
          end else if (scl_fall) begin
            reg_rd = 1'b1;
            nxt_tx = rd_data;
            nxt_drv = ~rd_data[7];
            nxt_ptr = ptr_ff + step;
            nxt_cnt = 4'h0;
            nxt_ist = I_RD;
          end
        end
        default: nxt_ist = I_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ist_ff <= I_IDLE;
      sr_ff <= 8'h00;
      tx_ff <= 8'h00;
      ptr_ff <= 8'h00;
      cnt_ff <= 4'h0;
      drv_ff <= 1'b0;
      first_ff <= 1'b0;
      rw_ff <= 1'b0;
    end else begin
      ist_ff <= nxt_ist;
      sr_ff <= nxt_sr;
      tx_ff <= nxt_tx;
      ptr_ff <= nxt_ptr;
      cnt_ff <= nxt_cnt;
      drv_ff <= nxt_drv;
      first_ff <= nxt_first;
      rw_ff <= nxt_rw;
    end
  end

  // Input events win the queue port; the scanner simply waits
  assign gpi_rec = gpi_event_i &&
    !(lock_state_i && cfg_ff[kpd_pkg::CFG_LOCK_TRACK]);
  assign ev.ready = !gpi_rec;
  assign push = gpi_rec || ev.valid;
  assign push_data = gpi_rec ? gpi_data_i : ev.data;
  assign pop = reg_rd && (ptr_ff == kpd_pkg::REG_EVT);

  kpd_fifo u_fifo (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n),
    .push_i(push),
    .data_i(push_data),
    .wrap_i(cfg_ff[kpd_pkg::CFG_WRAP_MODE]),
    .pop_i(pop),
    .data_o(fifo_data),
    .count_o(fifo_cnt),
    .lost_o(fifo_lost)
  );

  kpd_scan #(
    .SCAN_PERIOD_CYC(SCAN_PERIOD_CYC)
  ) u_scan (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n),
    .row_i(row_s2_ff),
    .col_o(col_o),
    .col_oe_n_o(col_oe_n_o),
    .ev(ev)
  );

  // Config, sticky status and the interrupt pin
  always_comb begin
    nxt_cfg = cfg_ff;
    if (reg_wr && ptr_ff == kpd_pkg::REG_CFG) begin
      nxt_cfg = sr_ff;
    end
    clr = 8'h00;
    if (reg_wr && ptr_ff == kpd_pkg::REG_INT_STAT) begin
      clr = sr_ff & kpd_pkg::STAT_MASK;
    end
    set = 8'h00;
    set[kpd_pkg::ST_KEY] = ev.valid && !gpi_rec
      && cfg_ff[kpd_pkg::CFG_KE_IEN];
    set[kpd_pkg::ST_GPI] = gpi_rec && cfg_ff[kpd_pkg::CFG_GPI_IEN];
    set[kpd_pkg::ST_LOCK] = lock_start_i
      && cfg_ff[kpd_pkg::CFG_LOCK_IRQ_EN];
    // Loss without wrap mode stays silent
    set[kpd_pkg::ST_WRAP] = fifo_lost && cfg_ff[kpd_pkg::CFG_WRAP_IRQ_EN]
      && cfg_ff[kpd_pkg::CFG_WRAP_MODE];
    set[kpd_pkg::ST_SALUTE] = ev.salute;
    // Unread events keep key and input status from clearing
    pend = (fifo_cnt != 4'h0);
    keep = 8'h00;
    keep[kpd_pkg::ST_KEY] = pend && stat_ff[kpd_pkg::ST_KEY];
    keep[kpd_pkg::ST_GPI] = pend && stat_ff[kpd_pkg::ST_GPI];
    nxt_stat = (stat_ff & ~clr) | set | (clr & keep);
    nxt_gap = (gap_ff != 11'h000) ? gap_ff - 11'h001 : gap_ff;
    if ((|(clr & keep)) && cfg_ff[kpd_pkg::CFG_INT_CFG]) begin
      nxt_gap = kpd_pkg::INT_GAP_LOAD;
    end
    nxt_int_oe_n = !((|nxt_stat) && (nxt_gap == 11'h000));
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ff <= kpd_pkg::CFG_RST;
      stat_ff <= 8'h00;
      gap_ff <= 11'h000;
      int_oe_n_ff <= 1'b1;
    end else begin
      cfg_ff <= nxt_cfg;
      stat_ff <= nxt_stat;
      gap_ff <= nxt_gap;
      int_oe_n_ff <= nxt_int_oe_n;
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_n_o = !drv_ff;
  assign int_o = 1'b0;
  assign int_oe_n_o = int_oe_n_ff;
  assign row_pu_en_o = pu_ff;
endmodule
